// ### bench/pme_event_select_tb.sv
// self-checking bench for the event selection block against an integer model
`timescale 1ns/10ps
module pme_event_select_tb;
  localparam logic [5:0] TBL [15] = '{6'h00, 6'h01, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h16, 6'h20, 6'h30,
    6'h31, 6'h3f, 6'h02, 6'h17, 6'h33};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clear_counts = 1'b0;
  logic monitor_enable = 1'b0;
  logic user_trace_enable = 1'b0;
  logic system_trace_enable = 1'b0;
  logic system_mode = 1'b0;
  logic [5:0] code [8] = '{default: 6'h3f};
  logic [63:0] rnd = '0;
  logic [31:0] seed = 32'h91486b41;
  logic [31:0] exp_c [8];
  logic [2:0] ck;
  logic [1:0] ab, db;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  wire [17:0] cm;
  wire [6:0] trp;
  wire [5:0] mmu, bsv;
  wire [7:0] l2v;
  wire sys_bus_clock, addr_bus_busy, data_bus_busy;
  wire [31:0] got [8];

  always #4 clock = ~clock;

  pme_event_src src_u (.*);
  pme_event_select dut_u (
    .*,
    .code_upper_0(code[0]), .code_lower_0(code[1]), .code_upper_1(code[2]), .code_lower_1(code[3]),
    .code_upper_2(code[4]), .code_lower_2(code[5]), .code_upper_3(code[6]), .code_lower_3(code[7]),
    .ev_commit_count(cm[2:0]), .ev_commit_ldst(cm[5:3]), .ev_commit_branch(cm[8:6]), .ev_commit_fpop(cm[11:9]),
    .ev_commit_fma(cm[14:12]), .ev_commit_prefetch(cm[17:15]),
    .ev_trap_int_vector(trp[0]), .ev_trap_int_level(trp[1]), .ev_trap_spill(trp[2]), .ev_trap_fill(trp[3]),
    .ev_trap_soft_inst(trp[4]), .ev_trap_inst_mmu_miss(trp[5]), .ev_trap_data_mmu_miss(trp[6]),
    .ev_inst_micro_tlb_miss(mmu[0]), .ev_data_micro_tlb_miss(mmu[1]), .ev_inst_l1_miss(mmu[2]),
    .ev_data_l1_miss(mmu[3]), .ev_inst_l1_miss_latency(mmu[4]), .ev_data_l1_miss_latency(mmu[5]),
    .ev_demand_l2_miss_wait(l2v[0]), .ev_prefetch_l2_miss_wait(l2v[1]), .ev_demand_l2_miss(l2v[2]),
    .ev_prefetch_l2_miss(l2v[3]), .ev_demand_l2_ref(l2v[4]), .ev_prefetch_l2_ref(l2v[5]),
    .ev_demand_miss_writeback(l2v[6]), .ev_prefetch_miss_writeback(l2v[7]),
    .snoop_invalidate_packet(bsv[0]), .snoop_copyback_inv_packet(bsv[1]), .snoop_copyback_packet(bsv[2]),
    .snoop_copyback_dirty_packet(bsv[3]), .ev_barrier_read(bsv[4]), .ev_barrier_write(bsv[5]),
    .upper_count_0(got[0]), .lower_count_0(got[1]), .upper_count_1(got[2]), .lower_count_1(got[3]),
    .upper_count_2(got[4]), .lower_count_2(got[5]), .upper_count_3(got[6]), .lower_count_3(got[7])
  );

  // ************************************************************
  // reference model
  // ************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int amt(int h, logic [5:0] c, logic [1:0] bus);
    case (c)
      6'h00: return 1;
      6'h01: return cm[2:0];
      6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c: return cm[3 * (c - 7) +: 3];
      6'h16: return (h == 0) ? $countones(trp) : trp[h - 1];
      6'h20: return (h < 2) ? 0 : mmu[h - 2];
      6'h30: return l2v[h];
      6'h31: return (h == 4 || h == 5) ? bus[h - 4] : bsv[(h < 4) ? h : h - 2];
      default: return 0;
    endcase
  endfunction

  always @(posedge clock) begin
    logic g;
    logic [1:0] bus;
    g = monitor_enable & (system_mode ? system_trace_enable : user_trace_enable);
    // bus-busy counts once per synced bus clock rise, not per core cycle
    bus = {db[1], ab[1]} & {2{ck[1] & ~ck[2]}};
    for (int h = 0; h < 8; h++)
      exp_c[h] = (!reset_n || clear_counts) ? 32'h0 : exp_c[h] + (g ? amt(h, code[h], bus) : 0);
    if (!reset_n) {ck, ab, db} = '0;
    else begin
      ck = {ck[1:0], sys_bus_clock};
      ab = {ab[0], addr_bus_busy};
      db = {db[0], data_bus_busy};
    end
  end

  task automatic chk(int h, logic [31:0] seen, logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] count half %0d expected %h seen %h", h, want, seen);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(negedge clock) begin
    cyc++;
    for (int h = 0; h < 8; h++)
      chk(h, got[h], exp_c[h]);
    if (cyc == 6000) begin
      num_errors++;
      end_sim();
    end
  end

  // ************************************************************
  // stimulus: codes redrawn every 40 cycles, gate and events every cycle
  // ************************************************************
  initial begin
    repeat (5) @(posedge clock);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clock);
      #1;
      rnd = {xs(), xs()};
      if (i % 40 == 0)
        foreach (code[h]) code[h] = TBL[xs() % 15];
      monitor_enable = |rnd[51:49];
      system_mode = rnd[52];
      user_trace_enable = |rnd[54:53];
      system_trace_enable = |rnd[56:55];
      clear_counts = (rnd[63:57] == 7'h0);
      // a second reset in mid-run
      reset_n = !(i >= 2000 && i < 2002);
    end
    end_sim();
  end
endmodule // pme_event_select_tb

// ### bench/pme_event_src.sv
// event source model: pipeline, cache, tlb and system bus activity
`timescale 1ns/10ps
module pme_event_src (
  input wire clock,
  input wire [63:0] rnd,
  output logic [17:0] cm,
  output logic [6:0] trp,
  output logic [5:0] mmu,
  output logic [7:0] l2v,
  output logic [5:0] bsv,
  output logic sys_bus_clock,
  output logic addr_bus_busy,
  output logic data_bus_busy
);
  logic [63:0] r;
  logic [2:0] ph;
  initial begin
    {cm, trp, mmu, l2v, bsv, sys_bus_clock, addr_bus_busy, data_bus_busy} = '0;
    ph = 3'h0;
  end
  // bus clock at a sixth of the core rate, three core cycles high and low
  always @(posedge clock) begin
    r = rnd;
    #1;
    ph = (ph == 3'h5) ? 3'h0 : ph + 3'h1;
    sys_bus_clock = (ph >= 3'h3);
    // busy only moves while the bus clock is low, settled well before the rise
    if (ph == 3'h0) {addr_bus_busy, data_bus_busy} = r[46:45];
    {l2v, mmu, trp, cm} = r[38:0];
    bsv = r[44:39];
  end
endmodule // pme_event_src

// ### bench/pme_properties.sv
// concurrent checks on the counter halves of the event selection block
`timescale 1ns/10ps
module pme_properties #(
  parameter COUNT_W = 32,
  parameter INC_W = 3
) (
  input wire clock,
  input wire reset_n,
  input wire clear_counts,
  input wire monitor_enable,
  input wire user_trace_enable,
  input wire system_trace_enable,
  input wire system_mode,
  input wire [5:0] code_upper_0, code_lower_0, code_upper_1, code_upper_2, code_lower_3,
  input wire [INC_W-1:0] ev_commit_count,
  input wire ev_trap_int_vector, ev_trap_int_level, ev_trap_spill, ev_trap_fill,
  input wire ev_trap_soft_inst, ev_trap_inst_mmu_miss, ev_trap_data_mmu_miss,
  input wire ev_prefetch_l2_miss_wait, ev_barrier_write,
  input wire sys_bus_clock, addr_bus_busy,
  input wire [COUNT_W-1:0] upper_count_0, lower_count_0, upper_count_1, upper_count_2, lower_count_3
);
  // ************************************************************
  // counting gate and trap total
  // ************************************************************
  wire cnt_ok = monitor_enable & (system_mode ? system_trace_enable : user_trace_enable) & ~clear_counts;
  // sum, not or: simultaneous traps must all land in the total
  wire [2:0] trap_sum = ev_trap_int_vector + ev_trap_int_level + ev_trap_spill + ev_trap_fill
    + ev_trap_soft_inst + ev_trap_inst_mmu_miss + ev_trap_data_mmu_miss;
  // helper copy of the two-flop bus sampling and the edge history behind it
  logic [2:0] bus_clk_hist;
  logic [1:0] addr_busy_hist;
  always @(posedge clock) begin
    bus_clk_hist <= reset_n ? {bus_clk_hist[1:0], sys_bus_clock} : 3'h0;
    addr_busy_hist <= reset_n ? {addr_busy_hist[0], addr_busy_bus_in()} : 2'h0;
  end
  function automatic logic addr_busy_bus_in();
    return addr_bus_busy;
  endfunction
  wire addr_tick = bus_clk_hist[1] & ~bus_clk_hist[2] & addr_busy_hist[1];
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  cycle_step_a: assert property (code_upper_0 == 6'h00 && cnt_ok |=> upper_count_0 == $past(upper_count_0) + 1'b1)
    else $error("cycle count did not step by one");
  instr_sum_a: assert property (code_lower_0 == 6'h01 && cnt_ok
    |=> lower_count_0 == $past(lower_count_0) + $past(ev_commit_count)) else $error("instruction count wrong");
  trap_total_a: assert property (code_upper_0 == 6'h16 && cnt_ok
    |=> upper_count_0 == $past(upper_count_0) + $past(trap_sum)) else $error("trap total wrong");
  mmu_half_zero_a: assert property (code_upper_0 == 6'h20 && !clear_counts |=> $stable(upper_count_0))
    else $error("reserved mmu code counted");
  reserved_hold_a: assert property (code_upper_1 inside {6'h02, 6'h17, 6'h33, 6'h3f} && !clear_counts
    |=> $stable(upper_count_1)) else $error("reserved code counted");
  gate_hold_a: assert property (!cnt_ok && !clear_counts |=> $stable(upper_count_2))
    else $error("count moved with gate closed");
  pf_wait_a: assert property (code_lower_0 == 6'h30 && cnt_ok
    |=> lower_count_0 == $past(lower_count_0) + $past(ev_prefetch_l2_miss_wait)) else $error("prefetch wait wrong");
  bar_write_a: assert property (code_lower_3 == 6'h31 && cnt_ok
    |=> lower_count_3 == $past(lower_count_3) + $past(ev_barrier_write)) else $error("barrier write wrong");
  bus_step_a: assert property (code_upper_2 == 6'h31 && cnt_ok
    |=> upper_count_2 == $past(upper_count_2) + $past(addr_tick)) else $error("address bus busy count wrong");
  cover property (code_upper_0 == 6'h16 && cnt_ok && trap_sum > 3'h1);
  cover property (code_upper_2 == 6'h31 && cnt_ok ##1 upper_count_2 != $past(upper_count_2));
  cover property (clear_counts ##1 upper_count_0 == '0);
endmodule // pme_properties

bind pme_event_select pme_properties #(.COUNT_W(COUNT_W), .INC_W(INC_W)) prop_u (.*);

// ### rtl/pme_counter.v
// one counter half: adds a per-cycle amount, wraps at full scale
`timescale 1ns/10ps
`include "pme_defines.vh"
module pme_counter #(
  parameter COUNT_W = `PME_COUNT_W,
  parameter INC_W = `PME_INC_W
) (
  input wire clock,
  input wire reset_n,
  input wire clear,
  input wire [INC_W-1:0] amount,
  output reg [COUNT_W-1:0] count
);

  wire [COUNT_W-1:0] next_count;

  // wraps silently; software watches for rollover itself
  assign next_count = count + {{(COUNT_W-INC_W){1'b0}}, amount};

  always @(posedge clock) begin
    if (!reset_n) begin
      count <= `PME_COUNT_RESET;
    end else if (clear) begin
      count <= `PME_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

endmodule // pme_counter

// ### rtl/pme_defines.vh
// event codes, widths and reset values for the performance-monitor event selection block
// What this block does
// - code 000000 counts core cycles while enabled, filtered by user/system trace enables.
// - code 000001 counts committed instructions exactly, mode filtered, for instructions per cycle.
// - code 001000 counts committed load/store instructions, atomic load-stores included.
// - code 001001 counts committed branches, including call, jump-and-link and return.
// - code 001010 counts committed floating-point operates, both groups, excluding fused multiply-add.
// - code 001011 counts committed fused multiply-add instructions only.
// - code 001100 counts committed prefetch instructions.
// - instruction-statistics codes work identically on all eight counter halves.
// - code 010110 on upper 0 counts every trap, equal to sum of typed counts.
// - code 100000 counts instruction/data micro-TLB misses on upper/lower 1.
// - code 100000 counts L1 instruction/data cache misses on upper/lower 2.
// - code 100000 accumulates L1 instruction/data miss latency on upper/lower 3.
// - code 110000 adds L2 miss wait cycles: demand upper 0, prefetch lower 0.
// - code 110000 counts L2 misses: demand upper 1, prefetch lower 1.
// - code 110000 counts L2 references: demand reads upper 2, prefetch lower 2.
// - code 110000 counts L2 misses with writeback: demand upper 3, prefetch lower 3.
// - code 110001 counts received snoop request packets on upper/lower 0 and 1.
// - code 110001 counts address/data bus busy cycles in bus clocks on half 2.
// - code 110001 counts barrier-register reads upper 3, writes lower 3.
`ifndef PME_DEFINES_VH
`define PME_DEFINES_VH

// ************************************************************
// event codes
// ************************************************************
`define PME_CODE_CYCLES 6'h00
`define PME_CODE_INSTR 6'h01
`define PME_CODE_LDST 6'h08
`define PME_CODE_BRANCH 6'h09
`define PME_CODE_FPOP 6'h0a
`define PME_CODE_FMA 6'h0b
`define PME_CODE_PREFETCH 6'h0c
`define PME_CODE_TRAP 6'h16
`define PME_CODE_MMU_L1 6'h20
`define PME_CODE_L2 6'h30
`define PME_CODE_BUS 6'h31
`define PME_CODE_DISABLED 6'h3f

// ************************************************************
// widths and reset values
// ************************************************************
`define PME_CODE_W 6
`define PME_COUNT_W 32
`define PME_INC_W 3
`define PME_HALVES 8
`define PME_COUNT_RESET 32'h0000_0000
`define PME_SYNC_RESET 1'b0

`endif

// ### rtl/pme_event_select.v
// performance-monitor event selection and eight counter halves
`timescale 1ns/10ps
`include "pme_defines.vh"
module pme_event_select #(
  parameter COUNT_W = `PME_COUNT_W,
  parameter INC_W = `PME_INC_W
) (
  input wire clock,
  input wire reset_n,
  input wire clear_counts,
  input wire monitor_enable,
  input wire user_trace_enable,
  input wire system_trace_enable,
  input wire system_mode,
  input wire [5:0] code_upper_0,
  input wire [5:0] code_lower_0,
  input wire [5:0] code_upper_1,
  input wire [5:0] code_lower_1,
  input wire [5:0] code_upper_2,
  input wire [5:0] code_lower_2,
  input wire [5:0] code_upper_3,
  input wire [5:0] code_lower_3,
  input wire [INC_W-1:0] ev_commit_count,
  input wire [INC_W-1:0] ev_commit_ldst,
  input wire [INC_W-1:0] ev_commit_branch,
  input wire [INC_W-1:0] ev_commit_fpop,
  input wire [INC_W-1:0] ev_commit_fma,
  input wire [INC_W-1:0] ev_commit_prefetch,
  input wire ev_trap_int_vector,
  input wire ev_trap_int_level,
  input wire ev_trap_spill,
  input wire ev_trap_fill,
  input wire ev_trap_soft_inst,
  input wire ev_trap_inst_mmu_miss,
  input wire ev_trap_data_mmu_miss,
  input wire ev_inst_micro_tlb_miss,
  input wire ev_data_micro_tlb_miss,
  input wire ev_inst_l1_miss,
  input wire ev_data_l1_miss,
  input wire ev_inst_l1_miss_latency,
  input wire ev_data_l1_miss_latency,
  input wire ev_demand_l2_miss_wait,
  input wire ev_prefetch_l2_miss_wait,
  input wire ev_demand_l2_miss,
  input wire ev_prefetch_l2_miss,
  input wire ev_demand_l2_ref,
  input wire ev_prefetch_l2_ref,
  input wire ev_demand_miss_writeback,
  input wire ev_prefetch_miss_writeback,
  input wire snoop_invalidate_packet,
  input wire snoop_copyback_inv_packet,
  input wire snoop_copyback_packet,
  input wire snoop_copyback_dirty_packet,
  input wire sys_bus_clock,
  input wire addr_bus_busy,
  input wire data_bus_busy,
  input wire ev_barrier_read,
  input wire ev_barrier_write,
  output wire [COUNT_W-1:0] upper_count_0,
  output wire [COUNT_W-1:0] lower_count_0,
  output wire [COUNT_W-1:0] upper_count_1,
  output wire [COUNT_W-1:0] lower_count_1,
  output wire [COUNT_W-1:0] upper_count_2,
  output wire [COUNT_W-1:0] lower_count_2,
  output wire [COUNT_W-1:0] upper_count_3,
  output wire [COUNT_W-1:0] lower_count_3
);

  // ************************************************************
  // half numbering: even = upper, odd = lower
  // ************************************************************
  localparam HALVES = `PME_HALVES;
  localparam CODE_W = `PME_CODE_W;
  localparam H_U0 = 0;
  localparam H_L0 = 1;
  localparam H_U1 = 2;
  localparam H_L1 = 3;
  localparam H_U2 = 4;
  localparam H_L2 = 5;
  localparam H_U3 = 6;
  localparam H_L3 = 7;

  // ************************************************************
  // helpers
  // ************************************************************
  function [INC_W-1:0] ext1;
    input bit_in;
    begin
      ext1 = {{(INC_W-1){1'b0}}, bit_in};
    end
  endfunction

  // shared decode for every half; group amounts are already half-specific
  function [INC_W-1:0] pick_amount;
    input [CODE_W-1:0] code;
    input [INC_W-1:0] ins;
    input [INC_W-1:0] ldst;
    input [INC_W-1:0] br;
    input [INC_W-1:0] fp;
    input [INC_W-1:0] fma;
    input [INC_W-1:0] pf;
    input [INC_W-1:0] grp_trap;
    input [INC_W-1:0] grp_mmu;
    input [INC_W-1:0] grp_l2;
    input [INC_W-1:0] grp_bus;
    begin
      case (code)
        `PME_CODE_CYCLES: pick_amount = ext1(1'b1);
        `PME_CODE_INSTR: pick_amount = ins;
        `PME_CODE_LDST: pick_amount = ldst;
        `PME_CODE_BRANCH: pick_amount = br;
        `PME_CODE_FPOP: pick_amount = fp;
        `PME_CODE_FMA: pick_amount = fma;
        `PME_CODE_PREFETCH: pick_amount = pf;
        `PME_CODE_TRAP: pick_amount = grp_trap;
        `PME_CODE_MMU_L1: pick_amount = grp_mmu;
        `PME_CODE_L2: pick_amount = grp_l2;
        `PME_CODE_BUS: pick_amount = grp_bus;
        default: pick_amount = {INC_W{1'b0}};
      endcase
    end
  endfunction

  // codes listed for a given half; the rest hold the count
  function half_listed;
    input [CODE_W-1:0] code;
    input integer half;
    begin
      case (code)
        `PME_CODE_CYCLES, `PME_CODE_INSTR, `PME_CODE_LDST, `PME_CODE_BRANCH: half_listed = 1'b1;
        `PME_CODE_FPOP, `PME_CODE_FMA, `PME_CODE_PREFETCH: half_listed = 1'b1;
        `PME_CODE_TRAP, `PME_CODE_L2, `PME_CODE_BUS: half_listed = 1'b1;
        `PME_CODE_MMU_L1: half_listed = (half >= H_U1);
        default: half_listed = 1'b0;
      endcase
    end
  endfunction

  // ************************************************************
  // mode filter
  // ************************************************************
  wire count_gate;

  // user and system both set counts every mode
  assign count_gate = monitor_enable &
                      (system_mode ? system_trace_enable : user_trace_enable);

  // ************************************************************
  // system bus clock sampling
  // ************************************************************
  // bus clock must run below half the core rate or edges are missed
  wire [2:0] bus_sampled;
  reg bus_clock_prev;
  wire bus_edge;

  pme_sync #(
    .WIDTH(3)
  ) bus_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({sys_bus_clock, addr_bus_busy, data_bus_busy}),
    .sync_out(bus_sampled)
  );

  always @(posedge clock) begin
    if (!reset_n) begin
      bus_clock_prev <= 1'b0;
    end else begin
      bus_clock_prev <= bus_sampled[2];
    end
  end

  // one count per bus-clock rise, not per core cycle
  assign bus_edge = bus_sampled[2] & ~bus_clock_prev;

  // busy shares the clock's flops, so both describe the same bus cycle
  wire addr_busy_tick;
  wire data_busy_tick;

  assign addr_busy_tick = bus_edge & bus_sampled[1];
  assign data_busy_tick = bus_edge & bus_sampled[0];

  // ************************************************************
  // trap group, code 010110
  // ************************************************************
  wire [HALVES*INC_W-1:0] trap_amt;
  wire [INC_W-1:0] trap_total;

  // summed rather than ored so simultaneous traps still match the typed halves
  assign trap_total = ext1(ev_trap_int_vector) + ext1(ev_trap_int_level) +
                      ext1(ev_trap_spill) + ext1(ev_trap_fill) +
                      ext1(ev_trap_soft_inst) + ext1(ev_trap_inst_mmu_miss) +
                      ext1(ev_trap_data_mmu_miss);
  assign trap_amt[H_U0*INC_W +: INC_W] = trap_total;
  assign trap_amt[H_L0*INC_W +: INC_W] = ext1(ev_trap_int_vector);
  assign trap_amt[H_U1*INC_W +: INC_W] = ext1(ev_trap_int_level);
  assign trap_amt[H_L1*INC_W +: INC_W] = ext1(ev_trap_spill);
  assign trap_amt[H_U2*INC_W +: INC_W] = ext1(ev_trap_fill);
  assign trap_amt[H_L2*INC_W +: INC_W] = ext1(ev_trap_soft_inst);
  assign trap_amt[H_U3*INC_W +: INC_W] = ext1(ev_trap_inst_mmu_miss);
  assign trap_amt[H_L3*INC_W +: INC_W] = ext1(ev_trap_data_mmu_miss);

  // ************************************************************
  // MMU and L1 cache group, code 100000
  // ************************************************************
  wire [HALVES*INC_W-1:0] mmu_amt;

  // half 0 reserved in this group
  assign mmu_amt[H_U0*INC_W +: INC_W] = {INC_W{1'b0}};
  assign mmu_amt[H_L0*INC_W +: INC_W] = {INC_W{1'b0}};
  // main TLB misses only show up through the MMU-miss trap halves
  assign mmu_amt[H_U1*INC_W +: INC_W] = ext1(ev_inst_micro_tlb_miss);
  assign mmu_amt[H_L1*INC_W +: INC_W] = ext1(ev_data_micro_tlb_miss);
  assign mmu_amt[H_U2*INC_W +: INC_W] = ext1(ev_inst_l1_miss);
  assign mmu_amt[H_L2*INC_W +: INC_W] = ext1(ev_data_l1_miss);
  // latency inputs are levels held while a miss is outstanding
  assign mmu_amt[H_U3*INC_W +: INC_W] = ext1(ev_inst_l1_miss_latency);
  assign mmu_amt[H_L3*INC_W +: INC_W] = ext1(ev_data_l1_miss_latency);

  // ************************************************************
  // L2 cache group, code 110000
  // ************************************************************
  wire [HALVES*INC_W-1:0] l2_amt;

  assign l2_amt[H_U0*INC_W +: INC_W] = ext1(ev_demand_l2_miss_wait);
  assign l2_amt[H_L0*INC_W +: INC_W] = ext1(ev_prefetch_l2_miss_wait);
  assign l2_amt[H_U1*INC_W +: INC_W] = ext1(ev_demand_l2_miss);
  assign l2_amt[H_L1*INC_W +: INC_W] = ext1(ev_prefetch_l2_miss);
  assign l2_amt[H_U2*INC_W +: INC_W] = ext1(ev_demand_l2_ref);
  assign l2_amt[H_L2*INC_W +: INC_W] = ext1(ev_prefetch_l2_ref);
  assign l2_amt[H_U3*INC_W +: INC_W] = ext1(ev_demand_miss_writeback);
  assign l2_amt[H_L3*INC_W +: INC_W] = ext1(ev_prefetch_miss_writeback);

  // ************************************************************
  // system bus and barrier group, code 110001
  // ************************************************************
  wire [HALVES*INC_W-1:0] bus_amt;

  assign bus_amt[H_U0*INC_W +: INC_W] = ext1(snoop_invalidate_packet);
  assign bus_amt[H_L0*INC_W +: INC_W] = ext1(snoop_copyback_inv_packet);
  assign bus_amt[H_U1*INC_W +: INC_W] = ext1(snoop_copyback_packet);
  assign bus_amt[H_L1*INC_W +: INC_W] = ext1(snoop_copyback_dirty_packet);
  assign bus_amt[H_U2*INC_W +: INC_W] = ext1(addr_busy_tick);
  assign bus_amt[H_L2*INC_W +: INC_W] = ext1(data_busy_tick);
  assign bus_amt[H_U3*INC_W +: INC_W] = ext1(ev_barrier_read);
  assign bus_amt[H_L3*INC_W +: INC_W] = ext1(ev_barrier_write);

  // ************************************************************
  // per-half selection and counters
  // ************************************************************
  wire [HALVES*CODE_W-1:0] code_all;
  wire [HALVES*COUNT_W-1:0] count_all;

  assign code_all = {code_lower_3, code_upper_3, code_lower_2, code_upper_2,
                     code_lower_1, code_upper_1, code_lower_0, code_upper_0};

  genvar h;
  generate
    for (h = 0; h < HALVES; h = h + 1) begin : g_half
      wire [INC_W-1:0] raw_amount;
      wire [INC_W-1:0] amount;
      wire listed;

      // same decode on every half, so instruction codes are universal
      assign raw_amount = pick_amount(code_all[h*CODE_W +: CODE_W],
                                      ev_commit_count, ev_commit_ldst,
                                      ev_commit_branch, ev_commit_fpop,
                                      ev_commit_fma, ev_commit_prefetch,
                                      trap_amt[h*INC_W +: INC_W],
                                      mmu_amt[h*INC_W +: INC_W],
                                      l2_amt[h*INC_W +: INC_W],
                                      bus_amt[h*INC_W +: INC_W]);

      // reserved group slots are zero already; this keeps the hold explicit
      assign listed = half_listed(code_all[h*CODE_W +: CODE_W], h);
      assign amount = (count_gate & listed) ? raw_amount : {INC_W{1'b0}};

      pme_counter #(
        .COUNT_W(COUNT_W),
        .INC_W(INC_W)
      ) half_counter (
        .clock(clock),
        .reset_n(reset_n),
        .clear(clear_counts),
        .amount(amount),
        .count(count_all[h*COUNT_W +: COUNT_W])
      );
    end
  endgenerate

  // ************************************************************
  // outputs, each straight from a counter register
  // ************************************************************
  assign upper_count_0 = count_all[H_U0*COUNT_W +: COUNT_W];
  assign lower_count_0 = count_all[H_L0*COUNT_W +: COUNT_W];
  assign upper_count_1 = count_all[H_U1*COUNT_W +: COUNT_W];
  assign lower_count_1 = count_all[H_L1*COUNT_W +: COUNT_W];
  assign upper_count_2 = count_all[H_U2*COUNT_W +: COUNT_W];
  assign lower_count_2 = count_all[H_L2*COUNT_W +: COUNT_W];
  assign upper_count_3 = count_all[H_U3*COUNT_W +: COUNT_W];
  assign lower_count_3 = count_all[H_L3*COUNT_W +: COUNT_W];

endmodule // pme_event_select

// ### rtl/pme_sync.v
// two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/10ps
`include "pme_defines.vh"
module pme_sync #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // stage_one is read by sync_out only
  always @(posedge clock) begin
    if (!reset_n) begin
      stage_one <= {WIDTH{`PME_SYNC_RESET}};
      sync_out <= {WIDTH{`PME_SYNC_RESET}};
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule // pme_sync
